// *** hw/ast_cfg.svh ***
`ifndef AST_CFG_SVH
`define AST_CFG_SVH

// register byte offsets on the wishbone slave
`define AST_OFS_DATA 8'h00
`define AST_OFS_FLAG 8'h04
`define AST_OFS_IBRD 8'h08
`define AST_OFS_FBRD 8'h0c
`define AST_OFS_LCRH 8'h10
`define AST_OFS_CTL 8'h14
`define AST_OFS_IFLS 8'h18

// port control register bits and reset value
`define AST_CTL_PORT_EN 0
`define AST_CTL_SIR_EN 1
`define AST_CTL_TX_EN 8
`define AST_CTL_RX_EN 9
`define AST_CTL_RESET 10'h300

// fifo level select: tx in [2:0], rx in [5:3], both at the half mark
`define AST_IFLS_RESET 6'h12

// flag register bit positions
`define AST_FLAG_BUSY 3
`define AST_FLAG_RX_EMPTY 4
`define AST_FLAG_TX_FULL 5
`define AST_FLAG_RX_FULL 6
`define AST_FLAG_TX_EMPTY 7
`define AST_FLAG_TX_LVL 8
`define AST_FLAG_RX_LVL 9

// oversampling tick positions inside one bit period
`define AST_SUB_MID 4'h7
`define AST_SUB_LAST 4'hf
`define AST_SIR_LAST 4'h2

// smallest character length
`define AST_MIN_BITS 4'h5

`endif

// *** hw/ast_pkg.sv ***
package ast_pkg;

  // line control fields, as written to the line control register
  typedef struct packed {
    logic stick;
    logic [1:0] wlen;
    logic fifo_enable_bit;
    logic stp2;
    logic eps;
    logic pen;
    logic brk;
  } ast_lcr_type;

  // 30-bit latched line setting: whole divisor, fraction, line control
  typedef struct packed {
    logic [15:0] ibrd;
    logic [5:0] fbrd;
    ast_lcr_type lcr;
  } ast_cfg_type;

  // receive fifo entry, same layout as a data register read
  typedef struct packed {
    logic oe;
    logic be;
    logic pe;
    logic fe;
    logic [7:0] data;
  } ast_rx_type;

  // transmit sequencer
  typedef enum logic [4:0] {
    ast_tx_idle = 5'b00001,
    ast_tx_start = 5'b00010,
    ast_tx_data = 5'b00100,
    ast_tx_par = 5'b01000,
    ast_tx_stop = 5'b10000
  } ast_tx_state_type;

  // receive sequencer
  typedef enum logic [4:0] {
    ast_rx_idle = 5'b00001,
    ast_rx_start = 5'b00010,
    ast_rx_data = 5'b00100,
    ast_rx_par = 5'b01000,
    ast_rx_stop = 5'b10000
  } ast_rx_state_type;

endpackage

// *** hw/ast_uart.sv ***
// The address map and the Wishbone register port are this design's own decisions.
`timescale 1ns/10ps
`include "ast_cfg.svh"
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// plain fifo; the caller sets how deep it may fill
module ast_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int CW = $clog2(DEPTH) + 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // fill side
  input wire logic push_i,
  input wire logic [WIDTH-1:0] wdata_i,
  // drain side
  input wire logic pop_i,
  output logic [WIDTH-1:0] rdata_o,
  // status
  input wire logic [CW-1:0] limit_i,
  output logic full_o,
  output logic empty_o,
  output logic [CW-1:0] count_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];  // entry storage
  logic [AW-1:0] wr_ptr_reg;  // next slot to fill
  logic [AW-1:0] rd_ptr_reg;  // oldest entry
  logic [CW-1:0] count_reg;  // entries held

  // storage written only on push; no reset needed for data
  always_ff @(posedge clk_i) begin
    if (push_i) begin
      mem[wr_ptr_reg] <= wdata_i;
    end
  end

  // pointers and fill count
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push_i) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop_i) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + CW'(push_i) - CW'(pop_i);
    end
  end

  // a lowered limit leaves surplus entries readable but blocks new ones
  assign full_o = count_reg >= limit_i;
  assign empty_o = count_reg == '0;
  assign count_o = count_reg;
  assign rdata_o = mem[rd_ptr_reg];
endmodule

////////////////////////////////////////////////////////////////////////////////
module ast_uart
  import ast_pkg::*;
#(
  parameter int FIFO_DEPTH = 16,
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // serial line
  input wire logic serial_in_i,
  output logic serial_out_o
);
  localparam int CW = $clog2(FIFO_DEPTH) + 1;

  // the level math needs eighths and the pointers need a power of two
  if (FIFO_DEPTH < 8 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad_depth
    $error("FIFO_DEPTH must be a power of two of at least 8");
  end

  // software registers
  logic [15:0] ibrd_reg;  // divisor_integer_register
  logic [5:0] fbrd_reg;  // divisor_fraction_register
  ast_cfg_type cfg_reg;  // latched divisor plus line control
  logic [9:0] ctl_reg;  // port_control_register
  logic [5:0] ifls_reg;  // fifo level selects
  // bus slave
  logic ack_reg;
  logic [31:0] dat_reg;
  logic bus_req, bus_wr, bus_rd;
  logic [31:0] rd_data;
  // baud generator
  logic [15:0] baud_cnt_reg;
  logic [5:0] frac_acc_reg;
  logic carry_reg;
  logic tick_reg;  // oversample_tick pulse
  // fifos
  logic tx_push, tx_pop, tx_full, tx_empty;
  logic [7:0] tx_rdata;
  logic [CW-1:0] tx_count;
  logic rx_push, rx_pop, rx_full, rx_empty;
  ast_rx_type rx_wdata, rx_rdata;
  logic [CW-1:0] rx_count, fifo_limit;
  // transmitter
  ast_tx_state_type tx_state_reg;
  logic [3:0] tx_sub_reg;
  logic [2:0] tx_bit_reg;
  logic [7:0] tx_shift_reg;
  logic tx_par_reg;
  logic tx_stop2_reg;  // first of two stop bits sent
  logic tx_line;
  logic out_reg;
  // receiver
  ast_rx_state_type rx_state_reg;
  logic [3:0] rx_sub_reg;
  logic [2:0] rx_bit_reg;
  logic [7:0] rx_data_reg;
  logic rx_pe_reg, rx_low_reg, rx_prev_reg, ovr_pend_reg;
  logic rx_sample;
  // derived settings
  logic port_en, busy, tx_lvl, rx_lvl;
  logic [2:0] last_bit;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // byte-lane merge of a write onto an old word
  function automatic logic [31:0] lane_merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // parity bit for a character already masked to its length
  function automatic logic par_bit(input ast_lcr_type lcr, input logic [7:0] d);
    logic p;
    p = lcr.eps ? ^d : ~^d;
    if (lcr.stick) begin
      p = ~lcr.eps;
    end
    return p;
  endfunction

  // fifo trigger level in entries, eighths of the depth
  function automatic logic [CW-1:0] level(input logic [2:0] sel);
    logic [CW-1:0] unit;
    unit = CW'(FIFO_DEPTH / 8);
    unique case (sel)
      3'h0: level = unit;
      3'h1: level = CW'(unit * 2);
      3'h3: level = CW'(unit * 6);
      3'h4: level = CW'(unit * 7);
      default: level = CW'(unit * 4);
    endcase
  endfunction

  assign port_en = ctl_reg[`AST_CTL_PORT_EN];
  assign last_bit = 3'(`AST_MIN_BITS - 4'h1) + {1'b0, cfg_reg.lcr.wlen};
  assign fifo_limit = cfg_reg.lcr.fifo_enable_bit ? CW'(FIFO_DEPTH) : CW'(1);

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave: one wait state, answer one cycle after the request
  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign bus_wr = bus_req & wb_we_i;
  assign bus_rd = bus_req & ~wb_we_i;

  // acknowledge drops the cycle after it is given
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req;
    end
  end

  // read mux; unmapped addresses answer zero
  always_comb begin
    rd_data = '0;
    unique case (wb_adr_i)
      `AST_OFS_DATA: rd_data = rx_empty ? '0 : 32'(rx_rdata);
      `AST_OFS_FLAG: begin
        rd_data[`AST_FLAG_BUSY] = busy;
        rd_data[`AST_FLAG_RX_EMPTY] = rx_empty;
        rd_data[`AST_FLAG_TX_FULL] = tx_full;
        rd_data[`AST_FLAG_RX_FULL] = rx_full;
        rd_data[`AST_FLAG_TX_EMPTY] = tx_empty;
        rd_data[`AST_FLAG_TX_LVL] = tx_lvl;
        rd_data[`AST_FLAG_RX_LVL] = rx_lvl;
      end
      `AST_OFS_IBRD: rd_data = 32'(ibrd_reg);
      `AST_OFS_FBRD: rd_data = 32'(fbrd_reg);
      `AST_OFS_LCRH: rd_data = 32'(cfg_reg.lcr);
      `AST_OFS_CTL: rd_data = 32'(ctl_reg);
      `AST_OFS_IFLS: rd_data = 32'(ifls_reg);
      default: rd_data = '0;
    endcase
  end

  // read data is held with the acknowledge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_reg <= '0;
    end else if (bus_rd) begin
      dat_reg <= rd_data;
    end
  end

  // control writes; the setting the line uses only moves on a line write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ibrd_reg <= '0;
      fbrd_reg <= '0;
      cfg_reg <= '0;
      ctl_reg <= `AST_CTL_RESET;
      ifls_reg <= `AST_IFLS_RESET;
    end else if (bus_wr) begin
      unique case (wb_adr_i)
        `AST_OFS_IBRD: ibrd_reg <= 16'(lane_merge(32'(ibrd_reg), wb_dat_i, wb_sel_i));
        `AST_OFS_FBRD: fbrd_reg <= 6'(lane_merge(32'(fbrd_reg), wb_dat_i, wb_sel_i));
        `AST_OFS_LCRH: begin
          cfg_reg.ibrd <= ibrd_reg;
          cfg_reg.fbrd <= fbrd_reg;
          cfg_reg.lcr <= 8'(lane_merge(32'(cfg_reg.lcr), wb_dat_i, wb_sel_i));
        end
        `AST_OFS_CTL: ctl_reg <= 10'(lane_merge(32'(ctl_reg), wb_dat_i, wb_sel_i));
        `AST_OFS_IFLS: ifls_reg <= 6'(lane_merge(32'(ifls_reg), wb_dat_i, wb_sel_i));
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // baud generator: whole part in clocks, fraction stretches by one clock
  // every time the 1/64 accumulator carries
  always_ff @(posedge clk_i) begin
    if (rst_i || cfg_reg.ibrd == '0) begin
      baud_cnt_reg <= '0;
      frac_acc_reg <= '0;
      carry_reg <= 1'b0;
      tick_reg <= 1'b0;
    end else if (17'(baud_cnt_reg) + 17'h1 >= 17'(cfg_reg.ibrd) + 17'(carry_reg)) begin
      baud_cnt_reg <= '0;
      {carry_reg, frac_acc_reg} <= 7'(frac_acc_reg) + 7'(cfg_reg.fbrd);
      tick_reg <= 1'b1;
    end else begin
      baud_cnt_reg <= baud_cnt_reg + 16'h1;
      tick_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fifos; writes to a full transmit fifo are dropped
  assign tx_push = bus_wr && wb_adr_i == `AST_OFS_DATA && !tx_full;
  assign rx_pop = bus_rd && wb_adr_i == `AST_OFS_DATA && !rx_empty;
  assign tx_lvl = tx_count <= level(ifls_reg[2:0]);
  assign rx_lvl = rx_count >= level(ifls_reg[5:3]);

  ast_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .clk_i(clk_i), .rst_i(rst_i), .push_i(tx_push), .wdata_i(wb_dat_i[7:0]),
    .pop_i(tx_pop), .rdata_o(tx_rdata), .limit_i(fifo_limit), .full_o(tx_full),
    .empty_o(tx_empty), .count_o(tx_count));

  ast_fifo #(.WIDTH(12), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .clk_i(clk_i), .rst_i(rst_i), .push_i(rx_push), .wdata_i(rx_wdata),
    .pop_i(rx_pop), .rdata_o(rx_rdata), .limit_i(fifo_limit), .full_o(rx_full),
    .empty_o(rx_empty), .count_o(rx_count));

  ////////////////////////////////////////////////////////////////////////////
  // transmitter; enables are only looked at in idle, so a frame in flight
  // always completes
  assign tx_pop = tx_state_reg == ast_tx_idle && port_en && ctl_reg[`AST_CTL_TX_EN] &&
                  !tx_empty;
  assign busy = !tx_empty || tx_state_reg != ast_tx_idle;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_state_reg <= ast_tx_idle;
      tx_sub_reg <= '0;
      tx_bit_reg <= '0;
      tx_shift_reg <= '0;
      tx_par_reg <= 1'b0;
      tx_stop2_reg <= 1'b0;
    end else if (tx_pop) begin
      tx_state_reg <= ast_tx_start;
      tx_sub_reg <= '0;
      tx_shift_reg <= tx_rdata;
      tx_par_reg <= par_bit(cfg_reg.lcr, tx_rdata & (8'hff >> (3'h3 - 3'(cfg_reg.lcr.wlen))));
      tx_stop2_reg <= 1'b0;
    end else if (tick_reg && tx_state_reg != ast_tx_idle) begin
      tx_sub_reg <= tx_sub_reg + 4'h1;
      if (tx_sub_reg == `AST_SUB_LAST) begin
        unique case (tx_state_reg)
          ast_tx_start: begin
            tx_state_reg <= ast_tx_data;
            tx_bit_reg <= '0;
          end
          ast_tx_data: begin
            tx_shift_reg <= tx_shift_reg >> 1;
            tx_bit_reg <= tx_bit_reg + 3'h1;
            if (tx_bit_reg == last_bit) begin
              tx_state_reg <= cfg_reg.lcr.pen ? ast_tx_par : ast_tx_stop;
            end
          end
          ast_tx_par: tx_state_reg <= ast_tx_stop;
          ast_tx_stop: begin
            // second stop bit when configured
            if (cfg_reg.lcr.stp2 && !tx_stop2_reg) begin
              tx_stop2_reg <= 1'b1;
            end else begin
              tx_state_reg <= ast_tx_idle;
            end
          end
          default: tx_state_reg <= ast_tx_idle;
        endcase
      end
    end
  end

  // line level per state; send-break forces the line low
  always_comb begin
    unique case (tx_state_reg)
      ast_tx_start: tx_line = 1'b0;
      ast_tx_data: tx_line = tx_shift_reg[0];
      ast_tx_par: tx_line = tx_par_reg;
      default: tx_line = 1'b1;
    endcase
    if (cfg_reg.lcr.brk) begin
      tx_line = 1'b0;
    end
  end

  // output flop; infrared mode turns each zero into a short high pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_reg <= 1'b1;
    end else if (ctl_reg[`AST_CTL_SIR_EN]) begin
      out_reg <= !tx_line && tx_sub_reg <= `AST_SIR_LAST;
    end else begin
      out_reg <= tx_line;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receiver
  assign rx_sample = tick_reg && rx_sub_reg == `AST_SUB_LAST;
  assign rx_wdata = '{oe: ovr_pend_reg, be: rx_low_reg && !serial_in_i,
                      pe: rx_pe_reg, fe: !serial_in_i, data: rx_data_reg};
  assign rx_push = rx_state_reg == ast_rx_stop && rx_sample && !rx_full;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_state_reg <= ast_rx_idle;
      rx_sub_reg <= '0;
      rx_bit_reg <= '0;
      rx_data_reg <= '0;
      rx_pe_reg <= 1'b0;
      rx_low_reg <= 1'b0;
      rx_prev_reg <= 1'b1;
    end else begin
      rx_prev_reg <= serial_in_i;
      unique case (rx_state_reg)
        ast_rx_idle: begin
          // only a falling edge from an idle-high line starts a frame
          if (port_en && ctl_reg[`AST_CTL_RX_EN] && rx_prev_reg && !serial_in_i) begin
            rx_state_reg <= ast_rx_start;
            rx_sub_reg <= '0;
          end
        end
        ast_rx_start: if (tick_reg) begin
          rx_sub_reg <= rx_sub_reg + 4'h1;
          if (rx_sub_reg == `AST_SUB_MID) begin
            // glitch filter: a start bit must still be low mid-bit
            rx_state_reg <= serial_in_i ? ast_rx_idle : ast_rx_data;
            rx_sub_reg <= '0;
            rx_bit_reg <= '0;
            rx_data_reg <= '0;
            rx_pe_reg <= 1'b0;
            rx_low_reg <= 1'b1;
          end
        end
        ast_rx_data: if (tick_reg) begin
          rx_sub_reg <= rx_sub_reg + 4'h1;
          if (rx_sample) begin
            rx_data_reg[rx_bit_reg] <= serial_in_i;
            rx_low_reg <= rx_low_reg && !serial_in_i;
            rx_bit_reg <= rx_bit_reg + 3'h1;
            if (rx_bit_reg == last_bit) begin
              rx_state_reg <= cfg_reg.lcr.pen ? ast_rx_par : ast_rx_stop;
            end
          end
        end
        ast_rx_par: if (tick_reg) begin
          rx_sub_reg <= rx_sub_reg + 4'h1;
          if (rx_sample) begin
            rx_pe_reg <= serial_in_i != par_bit(cfg_reg.lcr, rx_data_reg);
            rx_low_reg <= rx_low_reg && !serial_in_i;
            rx_state_reg <= ast_rx_stop;
          end
        end
        ast_rx_stop: if (tick_reg) begin
          rx_sub_reg <= rx_sub_reg + 4'h1;
          if (rx_sample) begin
            rx_state_reg <= ast_rx_idle;
          end
        end
        default: rx_state_reg <= ast_rx_idle;
      endcase
    end
  end

  // a character lost to a full fifo marks the next one stored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ovr_pend_reg <= 1'b0;
    end else if (rx_state_reg == ast_rx_stop && rx_sample && rx_full) begin
      ovr_pend_reg <= 1'b1;
    end else if (rx_push) begin
      ovr_pend_reg <= 1'b0;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign serial_out_o = out_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence seq_start_seen;
    rx_state_reg == ast_rx_start && tick_reg && rx_sub_reg == `AST_SUB_MID;
  endsequence

  sequence seq_stop_sample;
    rx_state_reg == ast_rx_stop && rx_sample && !rx_full;
  endsequence

  chk_enables_reset: assert property (
    $fell(rst_i) |-> ctl_reg[`AST_CTL_TX_EN] && ctl_reg[`AST_CTL_RX_EN])
    else $error("enables not set after reset");
  chk_finish_char: assert property (
    tx_state_reg != ast_tx_idle && !port_en && tick_reg |=>
      tx_sub_reg == $past(tx_sub_reg) + 4'h1)
    else $error("character cut short on disable");
  chk_start_low: assert property (
    tx_state_reg == ast_tx_start && !ctl_reg[`AST_CTL_SIR_EN] |=> !serial_out_o)
    else $error("start bit not low");
  chk_tick_space: assert property (
    tick_reg && cfg_reg.ibrd > 16'h0001 |=> !tick_reg)
    else $error("ticks closer than divisor");
  chk_latch_line: assert property (
    bus_wr && wb_adr_i != `AST_OFS_LCRH |=> $stable(cfg_reg))
    else $error("setting moved without line write");
  chk_busy_flag: assert property (
    bus_rd && wb_adr_i == `AST_OFS_FLAG && (!tx_empty || tx_state_reg != ast_tx_idle) |=>
      wb_dat_o[`AST_FLAG_BUSY])
    else $error("busy low while work pending");
  chk_start_reject: assert property (
    seq_start_seen ##0 serial_in_i |=> rx_state_reg == ast_rx_idle)
    else $error("high start bit accepted");
  chk_frame_error: assert property (
    seq_stop_sample ##0 !serial_in_i |-> rx_push && rx_wdata.fe)
    else $error("framing error not stored");
  chk_ir_pulse: assert property (
    ctl_reg[`AST_CTL_SIR_EN] && !tx_line && tx_sub_reg <= `AST_SIR_LAST |=> serial_out_o)
    else $error("infrared pulse missing");
  chk_single_depth: assert property (
    !cfg_reg.lcr.fifo_enable_bit && rx_count != '0 |-> rx_full)
    else $error("fifo deeper than one while disabled");

endmodule

`default_nettype wire

// *** dv/ast_remote.sv ***
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// far-end serial transceiver: sends frames to the port, samples its frames
module ast_remote (
  // clock
  input wire logic clk_i,
  // serial line
  input wire logic line_i,
  output logic line_o
);
  initial line_o = 1'b1; // idle mark level

  // drive n bits lsb first, clks cycles each, then return to idle
  task automatic send(input logic [11:0] bits, input int n, input int clks);
    @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      line_o <= bits[i];
      repeat (clks) @(posedge clk_i);
    end
    line_o <= 1'b1;
  endtask

  // wait for a start edge, then sample mid-bit; bound keeps a dead port from hanging
  task automatic grab(input int n, output logic [11:0] bits, output logic ok);
    ok = 1'b0;
    bits = '0;
    for (int t = 0; t < 4000 && !ok; t++) begin
      @(negedge clk_i);
      ok = (line_i === 1'b0);
    end
    repeat (7) @(negedge clk_i);
    for (int i = 0; i < n; i++) begin
      bits[i] = line_i;
      repeat (16) @(negedge clk_i);
    end
  endtask
endmodule

`default_nettype wire

// *** dv/async_serial_transceiver_test.sv ***
`timescale 1ns/10ps
`include "ast_cfg.svh"
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module async_serial_transceiver_test;
  typedef struct packed {
    logic [7:0] lcrh;
    logic [7:0] data;
    logic [11:0] rd;
    logic off;
  } ast_row_type;
  // wishbone master side
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  // serial line
  logic sin;
  logic sout;
  int err_total = 0;
  int checks_done = 0;
  logic [31:0] rd;
  logic [11:0] fr;
  logic [11:0] got;
  logic ok;
  int n;
  int hi;
  // 8n1 with a mid-frame disable, 5e2, 7o1, 6-bit stick one, 8-bit stick zero
  ast_row_type rows [5] = '{'{8'h60, 8'ha5, 12'h0a5, 1'b1}, '{8'h0e, 8'h13, 12'h013, 1'b0},
    '{8'h42, 8'h7e, 12'h07e, 1'b0}, '{8'ha2, 8'h2d, 12'h02d, 1'b0},
    '{8'he6, 8'h81, 12'h081, 1'b0}};

  always #5 clk_i = ~clk_i;

  ast_uart ast_uart_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .serial_in_i(sin), .serial_out_o(sout));
  ast_remote ast_remote_inst (.clk_i(clk_i), .line_i(sout), .line_o(sin));

  task automatic print_verdict();
    $display("errors %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // one classic cycle; request held to the rising edge that sees ack, released there
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    logic hit;
    hit = 1'b0;
    q = '0;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat_i <= d;
    for (int t = 0; t < 50 && !hit; t++) begin
      @(posedge clk_i);
      hit = (wb_ack_o === 1'b1);
      if (hit) begin
        q = wb_dat_o;
      end
    end
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (!hit) begin
      err_total++;
      print_verdict();
    end
  endtask

  // port off before touching line settings, back on afterwards
  task automatic cfg(input logic [7:0] l);
    wb(1'b1, `AST_OFS_CTL, 32'h300, rd);
    wb(1'b1, `AST_OFS_LCRH, {24'h0, l}, rd);
    wb(1'b1, `AST_OFS_CTL, 32'h301, rd);
  endtask

  // expected frame bits, start bit in bit 0
  function automatic logic [11:0] frame(input logic [7:0] l, input logic [7:0] d,
                                        output int k);
    int len;
    logic [7:0] dm;
    frame = '0;
    len = int'(l[6:5]) + 5;
    dm = d & ~(8'hff << len);
    for (int i = 0; i < len; i++) frame[1 + i] = dm[i];
    k = 1 + len;
    if (l[1]) begin
      frame[k] = l[7] ? ~l[2] : (l[2] ? ^dm : ~^dm);
      k++;
    end
    frame[k] = 1'b1;
    k = k + 1 + int'(l[3]);
    if (l[3]) frame[k - 1] = 1'b1;
  endfunction

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, `AST_OFS_CTL, 32'h0, rd);
    check(rd, {22'h0, `AST_CTL_RESET});
    wb(1'b0, `AST_OFS_IFLS, 32'h0, rd);
    check(rd, {26'h0, `AST_IFLS_RESET});
    wb(1'b0, `AST_OFS_FLAG, 32'h0, rd);
    check(rd & 32'hf8, 32'h90);
    wb(1'b0, 8'h1c, 32'h0, rd);
    check(rd, 32'h0);
    // 100 mhz over 16 x 6.25 mbaud: divisor exactly 1, fraction rounds to 0
    wb(1'b1, `AST_OFS_IBRD, 32'h1, rd);
    wb(1'b1, `AST_OFS_FBRD, 32'h0, rd);
    foreach (rows[r]) begin
      cfg(rows[r].lcrh);
      fr = frame(rows[r].lcrh, rows[r].data, n);
      wb(1'b1, `AST_OFS_DATA, {24'h0, rows[r].data}, rd);
      fork
        ast_remote_inst.grab(n, got, ok);
        begin
          wb(1'b0, `AST_OFS_FLAG, 32'h0, rd);
          check(rd[3], 1'b1);
          if (rows[r].off) wb(1'b1, `AST_OFS_CTL, 32'h300, rd);
        end
      join
      check(ok, 1'b1);
      check(got, fr);
      wb(1'b0, `AST_OFS_FLAG, 32'h0, rd);
      check(rd[3], 1'b0);
      wb(1'b1, `AST_OFS_CTL, 32'h301, rd);
      ast_remote_inst.send(fr, n, 16);
      wb(1'b0, `AST_OFS_DATA, 32'h0, rd);
      check(rd[11:0], rows[r].rd);
    end
    cfg(8'h66);
    fr = frame(8'h66, 8'h33, n);
    ast_remote_inst.send(fr ^ 12'h200, n, 16);
    wb(1'b0, `AST_OFS_DATA, 32'h0, rd);
    check(rd[11:0], 12'h233);
    cfg(8'h60);
    // divisor change without a line write must leave the bit period alone
    wb(1'b1, `AST_OFS_IBRD, 32'h3, rd);
    ast_remote_inst.send(12'h0b4, 10, 16);
    wb(1'b0, `AST_OFS_DATA, 32'h0, rd);
    check(rd[11:0], 12'h15a);
    ast_remote_inst.send(12'h000, 10, 16);
    wb(1'b0, `AST_OFS_DATA, 32'h0, rd);
    check(rd[11:0], 12'h500);
    ast_remote_inst.send(12'h000, 1, 4);
    repeat (40) @(posedge clk_i);
    wb(1'b0, `AST_OFS_FLAG, 32'h0, rd);
    check(rd[4], 1'b1);
    // the stored divisor of three now takes effect: 48 clocks per bit
    cfg(8'h60);
    fr = frame(8'h60, 8'h53, n);
    ast_remote_inst.send(fr, n, 48);
    wb(1'b0, `AST_OFS_DATA, 32'h0, rd);
    check(rd[11:0], 12'h053);
    // port off: fifo one deep until enabled, then a zero byte sent in infrared
    wb(1'b1, `AST_OFS_CTL, 32'h300, rd);
    wb(1'b1, `AST_OFS_DATA, 32'h0, rd);
    wb(1'b0, `AST_OFS_FLAG, 32'h0, rd);
    check(rd[5], 1'b1);
    wb(1'b1, `AST_OFS_IBRD, 32'h1, rd);
    wb(1'b1, `AST_OFS_LCRH, 32'h70, rd);
    wb(1'b0, `AST_OFS_FLAG, 32'h0, rd);
    check(rd[5], 1'b0);
    wb(1'b1, `AST_OFS_CTL, 32'h303, rd);
    // start plus eight zero bits, each a pulse three ticks long
    hi = 0;
    repeat (200) begin
      @(posedge clk_i);
      hi = hi + int'(sout);
    end
    check(hi, 32'h1b);
    wb(1'b1, `AST_OFS_CTL, 32'h301, rd);
    print_verdict();
  end
endmodule

`default_nettype wire
